/* src/smtc_pkg.sv */
// Contract
// - Style 0: signed limit, one threshold
// - Style 1: 7-bit magnitude, two opposite thresholds
// - Bit 4 selects low current or noise
// - Bit 3 set bypasses bus glitch filter
// - Bit 2 picks command or pin trigger
// - Running conversion finishes before next trigger
// - Triggers while one pending are dropped
// - Trigger source acts only in standby
// - Power state codes: standby, sleep, continuous, duty
// - Self exit from duty updates stored state
// - Channel select codes axes and sequences
// - Idle interval code sets duty sleep time
// - Crossing count one or four before flag
// - Direction bit: above or below threshold
// - Direction ignored when style above one
// - Gain target: first or second channel
// - Angle pair field selects axis pair
// - Planar range bit doubles X/Y range
// - Vertical range bit doubles Z range
// - Zero limit code disables axis comparison
//
// Purpose : Constants of the sensor mode and threshold configuration bank
// Assumes : 100 MHz system clock
// Notes   : Offsets are register addresses on the internal register port
package smtc_pkg;

  // ---------------------------------------------------------------
  // Register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_POWER_TRIGGER   = 8'h01;
  localparam logic [7:0] OFS_CHANNEL_INTERVAL = 8'h02;
  localparam logic [7:0] OFS_THRESHOLD_ANGLE = 8'h03;
  localparam logic [7:0] RST_POWER_TRIGGER   = 8'h00;
  localparam logic [7:0] RST_CHANNEL_INTERVAL = 8'h00;
  localparam logic [7:0] RST_THRESHOLD_ANGLE = 8'h00;
  localparam logic [7:0] MASK_THRESHOLD_ANGLE = 8'h7f;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int POS_STYLE_LSB    = 5;
  localparam int POS_NOISE_POWER  = 4;
  localparam int POS_GLITCH_BYP   = 3;
  localparam int POS_TRIG_SRC     = 2;
  localparam int POS_MODE_LSB     = 0;
  localparam int POS_CHSEL_LSB    = 4;
  localparam int POS_INTERVAL_LSB = 0;
  localparam int POS_CROSS_CNT    = 6;
  localparam int POS_DIRECTION    = 5;
  localparam int POS_GAIN_TARGET  = 4;
  localparam int POS_ANGLE_LSB    = 2;
  localparam int POS_RANGE_XY     = 1;
  localparam int POS_RANGE_Z      = 0;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_STANDBY    = 2'h0;
  localparam logic [1:0] MODE_SLEEP      = 2'h1;
  localparam logic [1:0] MODE_CONTINUOUS = 2'h2;
  localparam logic [1:0] MODE_DUTY       = 2'h3;
  localparam logic [2:0] STYLE_SIGNED    = 3'h0;
  localparam logic [2:0] STYLE_MAGNITUDE = 3'h1;
  localparam logic [1:0] AXIS_X          = 2'h1;
  localparam logic [1:0] AXIS_Y          = 2'h2;
  localparam logic [1:0] AXIS_Z          = 2'h3;
  localparam logic [2:0] CROSS_ONE       = 3'h1;
  localparam logic [2:0] CROSS_FOUR      = 3'h4;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int MS_NS          = 1000000;
  localparam int MS_TICK_CYCLES = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_CONV  = 3'b010,
    ST_DOZE  = 3'b100
  } smtc_state_type;

endpackage : smtc_pkg

/* src/smtc_config.sv */
// Purpose : Mode, trigger and threshold configuration bank with its sequencer
// Assumes : Register port driven by the bus engine on the same clock
// Notes   : Trigger pin is asynchronous and active low
`timescale 1ns/1ps
module smtc_config
  import smtc_pkg::*;
#(
  parameter int MS_TICKS = MS_TICK_CYCLES
) (
  input  wire logic       CLK_SYS,
  input  wire logic       ARST_N,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  input  wire logic       CMD_TRIG,
  input  wire logic       TRIG_PIN_N,
  input  wire logic       DUTY_EXIT,
  input  wire logic       CONV_DONE,
  input  wire logic       RESULT_VALID,
  input  wire logic [7:0] FIELD_X,
  input  wire logic [7:0] FIELD_Y,
  input  wire logic [7:0] FIELD_Z,
  input  wire logic [7:0] LIMIT_X,
  input  wire logic [7:0] LIMIT_Y,
  input  wire logic [7:0] LIMIT_Z,
  output logic            CONV_START,
  output logic            CONV_BUSY,
  output logic [1:0]      POWER_STATE,
  output logic            LOW_NOISE,
  output logic            GLITCH_BYPASS,
  output logic [2:0]      AXIS_ENABLE,
  output logic            AXIS_SEQUENCE,
  output logic            ANGLE_ENABLE,
  output logic [1:0]      ANGLE_FIRST,
  output logic [1:0]      ANGLE_SECOND,
  output logic [1:0]      GAIN_AXIS,
  output logic            RANGE_XY_DOUBLE,
  output logic            RANGE_Z_DOUBLE,
  output logic            THRESH_EVENT
);

  // Elaboration check: the prescaler cannot count below one cycle
  if (MS_TICKS < 1) begin : g_ticks_check
    $error("MS_TICKS must be at least one");
  end


  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // Axis enables in X,Y,Z bit order; reserved codes enable nothing
  function automatic logic [2:0] chsel_axes(input logic [3:0] code);
    unique case (code)
      4'h8, 4'h9: chsel_axes = 3'b011;
      4'ha:       chsel_axes = 3'b110;
      4'hb:       chsel_axes = 3'b101;
      default:    chsel_axes = (code < 4'h8) ? code[2:0] : 3'b000;
    endcase
  endfunction

  // Idle interval in milliseconds
  function automatic logic [14:0] interval_ms(input logic [3:0] code);
    unique case (code)
      4'h0: interval_ms = 15'd1;
      4'h1: interval_ms = 15'd5;
      4'h2: interval_ms = 15'd10;
      4'h3: interval_ms = 15'd15;
      4'h4: interval_ms = 15'd20;
      4'h5: interval_ms = 15'd30;
      4'h6: interval_ms = 15'd50;
      4'h7: interval_ms = 15'd100;
      4'h8: interval_ms = 15'd500;
      4'h9: interval_ms = 15'd1000;
      4'ha: interval_ms = 15'd2000;
      4'hb: interval_ms = 15'd5000;
      default: interval_ms = 15'd20000;
    endcase
  endfunction

  // One axis limit check; reserved styles never report a crossing
  function automatic logic axis_cross(input logic [7:0] field, input logic [7:0] limit,
                                      input logic [2:0] style, input logic dir);
    logic [7:0] mag;
    logic [7:0] fabs;
    mag  = {1'b0, limit[6:0]};
    fabs = field[7] ? 8'(-field) : field;
    axis_cross = 1'b0;
    if (limit != 8'h00) begin
      if (style == STYLE_SIGNED) begin
        axis_cross = dir ? ($signed(field) < $signed(limit))
                         : ($signed(field) > $signed(limit));
      end else if (style == STYLE_MAGNITUDE && mag != 8'h00) begin
        axis_cross = dir ? (fabs < mag) : (fabs > mag);
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]     pt_reg;
  logic [7:0]     ci_reg;
  logic [7:0]     ta_reg;
  logic [7:0]     rdata_reg;

  wire wr_pt = REG_WR && (REG_ADDR == OFS_POWER_TRIGGER);
  wire wr_ci = REG_WR && (REG_ADDR == OFS_CHANNEL_INTERVAL);
  wire wr_ta = REG_WR && (REG_ADDR == OFS_THRESHOLD_ANGLE);

  wire [2:0] style     = pt_reg[POS_STYLE_LSB +: 3];
  wire       trig_src  = pt_reg[POS_TRIG_SRC];
  wire [1:0] mode      = pt_reg[POS_MODE_LSB +: 2];
  wire [3:0] chsel     = ci_reg[POS_CHSEL_LSB +: 4];
  wire [3:0] interval  = ci_reg[POS_INTERVAL_LSB +: 4];
  wire       cross4    = ta_reg[POS_CROSS_CNT];
  wire       direction = ta_reg[POS_DIRECTION];
  wire [1:0] angle     = ta_reg[POS_ANGLE_LSB +: 2];

  // Hardware exit from duty mode wins over a host write in the same cycle
  wire       self_exit = DUTY_EXIT && (mode == MODE_DUTY);
  wire [7:0] pt_next   = self_exit ? {pt_reg[7:2], MODE_STANDBY}
                                   : (wr_pt ? REG_WDATA : pt_reg);

  wire [7:0] rd_mux = (REG_ADDR == OFS_POWER_TRIGGER)    ? pt_reg :
                      (REG_ADDR == OFS_CHANNEL_INTERVAL) ? ci_reg :
                      (REG_ADDR == OFS_THRESHOLD_ANGLE)  ? ta_reg : 8'h00;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pt_reg    <= RST_POWER_TRIGGER;
      ci_reg    <= RST_CHANNEL_INTERVAL;
      ta_reg    <= RST_THRESHOLD_ANGLE;
      rdata_reg <= 8'h00;
    end else begin
      pt_reg    <= pt_next;
      ci_reg    <= wr_ci ? REG_WDATA : ci_reg;
      ta_reg    <= wr_ta ? (REG_WDATA & MASK_THRESHOLD_ANGLE) : ta_reg;
      rdata_reg <= REG_RD ? rd_mux : rdata_reg;
    end
  end

  // ---------------------------------------------------------------
  // Trigger pin synchroniser
  // ---------------------------------------------------------------
  logic [2:0] pin_sync_reg;
  logic       pin_level_reg;

  wire pin_agree = (pin_sync_reg[1] == pin_sync_reg[2]);
  wire pin_fall  = pin_agree && pin_level_reg && !pin_sync_reg[2];

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_sync_reg  <= 3'b111;
      pin_level_reg <= 1'b1;
    end else begin
      pin_sync_reg  <= {pin_sync_reg[1:0], TRIG_PIN_N};
      pin_level_reg <= pin_agree ? pin_sync_reg[2] : pin_level_reg;
    end
  end

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  smtc_state_type state_reg;
  smtc_state_type state_next;
  logic           pend_reg;
  logic           pend_next;
  logic           start_reg;
  logic           start_next;
  logic [31:0]    tick_reg;
  logic [14:0]    ms_reg;

  // Trigger source only matters in standby
  wire trig_evt  = (mode == MODE_STANDBY)
                   && (trig_src ? pin_fall : CMD_TRIG);
  wire doze_done = (ms_reg >= interval_ms(interval));

  always_comb begin
    state_next = state_reg;
    pend_next  = pend_reg && (mode == MODE_STANDBY);
    start_next = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (trig_evt || mode == MODE_CONTINUOUS || mode == MODE_DUTY) begin
          state_next = ST_CONV;
          start_next = 1'b1;
        end
      end
      ST_CONV: begin
        if (CONV_DONE) begin
          // A trigger landing with done is served, not lost
          if (pend_next || trig_evt || mode == MODE_CONTINUOUS) begin
            start_next = 1'b1;
            pend_next  = 1'b0;
          end else if (mode == MODE_DUTY && !self_exit) begin
            state_next = ST_DOZE;
          end else begin
            state_next = ST_IDLE;
          end
        end else if (trig_evt) begin
          pend_next = 1'b1;
        end
      end
      ST_DOZE: begin
        if (mode != MODE_DUTY || self_exit) begin
          state_next = ST_IDLE;
        end else if (doze_done) begin
          state_next = ST_CONV;
          start_next = 1'b1;
        end
      end
    endcase
  end

  // Millisecond prescaler keeps the long idle counts out of one wide counter
  wire tick_wrap = (tick_reg == 32'(MS_TICKS - 1));

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= ST_IDLE;
      pend_reg  <= 1'b0;
      start_reg <= 1'b0;
      tick_reg  <= 32'h0;
      ms_reg    <= 15'h0;
    end else begin
      state_reg <= state_next;
      pend_reg  <= pend_next;
      start_reg <= start_next;
      tick_reg  <= (state_reg != ST_DOZE || tick_wrap) ? 32'h0 : tick_reg + 32'h1;
      ms_reg    <= (state_reg != ST_DOZE) ? 15'h0 : (tick_wrap ? ms_reg + 15'h1 : ms_reg);
    end
  end

  // ---------------------------------------------------------------
  // Threshold crossing counter
  // ---------------------------------------------------------------
  logic [2:0] cross_cnt_reg;
  logic       thresh_reg;

  wire [2:0] axes     = chsel_axes(chsel);
  wire       crossing = RESULT_VALID && (
                        (axes[0] && axis_cross(FIELD_X, LIMIT_X, style, direction)) ||
                        (axes[1] && axis_cross(FIELD_Y, LIMIT_Y, style, direction)) ||
                        (axes[2] && axis_cross(FIELD_Z, LIMIT_Z, style, direction)));
  wire [2:0] cross_goal = cross4 ? CROSS_FOUR : CROSS_ONE;
  wire [2:0] cross_inc  = cross_cnt_reg + 3'h1;
  wire       cross_hit  = crossing && (cross_inc >= cross_goal);

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cross_cnt_reg <= 3'h0;
      thresh_reg    <= 1'b0;
    end else begin
      cross_cnt_reg <= cross_hit ? 3'h0 : (crossing ? cross_inc : cross_cnt_reg);
      thresh_reg    <= cross_hit;
    end
  end

  // ---------------------------------------------------------------
  // Registered configuration decode
  // ---------------------------------------------------------------
  logic [2:0] axis_en_reg;
  logic       seq_reg;
  logic       angle_en_reg;
  logic [1:0] first_reg;
  logic [1:0] second_reg;
  logic [1:0] gain_reg;

  wire [1:0] first_axis  = (angle == 2'h2) ? AXIS_Y : AXIS_X;
  wire [1:0] second_axis = (angle == 2'h1) ? AXIS_Y : AXIS_Z;
  wire       angle_on    = (angle != 2'h0);

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      axis_en_reg  <= 3'h0;
      seq_reg      <= 1'b0;
      angle_en_reg <= 1'b0;
      first_reg    <= 2'h0;
      second_reg   <= 2'h0;
      gain_reg     <= 2'h0;
    end else begin
      axis_en_reg  <= axes;
      seq_reg      <= chsel[3] && (chsel < 4'hc);
      angle_en_reg <= angle_on;
      first_reg    <= angle_on ? first_axis : 2'h0;
      second_reg   <= angle_on ? second_axis : 2'h0;
      gain_reg     <= !angle_on ? 2'h0
                      : (ta_reg[POS_GAIN_TARGET] ? second_axis : first_axis);
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign REG_RDATA       = rdata_reg;
  assign CONV_START      = start_reg;
  assign CONV_BUSY       = state_reg[1];
  assign POWER_STATE     = pt_reg[POS_MODE_LSB +: 2];
  assign LOW_NOISE       = pt_reg[POS_NOISE_POWER];
  assign GLITCH_BYPASS   = pt_reg[POS_GLITCH_BYP];
  assign AXIS_ENABLE     = axis_en_reg;
  assign AXIS_SEQUENCE   = seq_reg;
  assign ANGLE_ENABLE    = angle_en_reg;
  assign ANGLE_FIRST     = first_reg;
  assign ANGLE_SECOND    = second_reg;
  assign GAIN_AXIS       = gain_reg;
  assign RANGE_XY_DOUBLE = ta_reg[POS_RANGE_XY];
  assign RANGE_Z_DOUBLE  = ta_reg[POS_RANGE_Z];
  assign THRESH_EVENT    = thresh_reg;

endmodule // smtc_config

/* sim/smtc_config_asserts.sv */
// Purpose : Port-level checks of the configuration bank
// Assumes : One clock domain, asynchronous active-low reset
// Notes   : Field copies are kept so that decode lag can be checked
`timescale 1ns/1ps
module smtc_config_asserts
  import smtc_pkg::*;
(
  input wire logic       CLK_SYS,
  input wire logic       ARST_N,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic       DUTY_EXIT,
  input wire logic       CONV_DONE,
  input wire logic       RESULT_VALID,
  input wire logic       CONV_START,
  input wire logic       CONV_BUSY,
  input wire logic [1:0] POWER_STATE,
  input wire logic       LOW_NOISE,
  input wire logic       GLITCH_BYPASS,
  input wire logic [2:0] AXIS_ENABLE,
  input wire logic       AXIS_SEQUENCE,
  input wire logic       ANGLE_ENABLE,
  input wire logic       RANGE_XY_DOUBLE,
  input wire logic       RANGE_Z_DOUBLE,
  input wire logic       THRESH_EVENT
);
  // ----------------------------------------
  // Field copies
  // ----------------------------------------
  logic [3:0] chsel_reg;
  logic [1:0] angle_reg;
  logic       wr_ch;
  logic       wr_ang;

  assign wr_ch  = REG_WR && REG_ADDR == OFS_CHANNEL_INTERVAL;
  assign wr_ang = REG_WR && REG_ADDR == OFS_THRESHOLD_ANGLE;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      chsel_reg <= 4'h0;
      angle_reg <= 2'h0;
    end else if (wr_ch) begin
      chsel_reg <= REG_WDATA[7:4];
    end else if (wr_ang) begin
      angle_reg <= REG_WDATA[3:2];
    end
  end

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  rd_ctl_a: assert property (
    REG_RD && !REG_WR && !DUTY_EXIT && REG_ADDR == OFS_POWER_TRIGGER |=> REG_RDATA[1:0] ==
    POWER_STATE && REG_RDATA[4] == LOW_NOISE && REG_RDATA[3] == GLITCH_BYPASS)
    else $error("control readback differs from outputs");
  rd_range_a: assert property (
    REG_RD && !REG_WR && REG_ADDR == OFS_THRESHOLD_ANGLE |=> !REG_RDATA[7] &&
    REG_RDATA[1:0] == {RANGE_XY_DOUBLE, RANGE_Z_DOUBLE})
    else $error("range readback differs from outputs");
  start_pulse_a: assert property (
    CONV_START |-> CONV_BUSY ##1 !CONV_START)
    else $error("start pulse not single or not busy");
  busy_hold_a: assert property (
    CONV_BUSY && !CONV_DONE |=> !CONV_START)
    else $error("start while conversion running");
  busy_drop_a: assert property (
    CONV_DONE && CONV_BUSY |=> !CONV_BUSY || CONV_START)
    else $error("busy kept after done");
  sleep_quiet_a: assert property (
    POWER_STATE == MODE_SLEEP && $past(POWER_STATE) == MODE_SLEEP |-> !CONV_START)
    else $error("start in sleep");
  duty_exit_a: assert property (
    DUTY_EXIT && POWER_STATE == MODE_DUTY |=> POWER_STATE == MODE_STANDBY)
    else $error("duty exit not stored");
  chsel_a: assert property (
    wr_ch ##1 !wr_ch |=> AXIS_SEQUENCE == chsel_reg[3] &&
    (chsel_reg[3] || AXIS_ENABLE == chsel_reg[2:0]))
    else $error("axis decode wrong");
  angle_a: assert property (
    wr_ang ##1 !wr_ang |=> ANGLE_ENABLE == (angle_reg != 2'h0))
    else $error("angle enable wrong");
  thr_event_a: assert property (
    THRESH_EVENT |-> $past(RESULT_VALID))
    else $error("event without result");
endmodule // smtc_config_asserts

bind smtc_config smtc_config_asserts u_chk (
  .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .DUTY_EXIT(DUTY_EXIT), .CONV_DONE(CONV_DONE), .RESULT_VALID(RESULT_VALID),
  .CONV_START(CONV_START), .CONV_BUSY(CONV_BUSY), .POWER_STATE(POWER_STATE),
  .LOW_NOISE(LOW_NOISE), .GLITCH_BYPASS(GLITCH_BYPASS), .AXIS_ENABLE(AXIS_ENABLE),
  .AXIS_SEQUENCE(AXIS_SEQUENCE), .ANGLE_ENABLE(ANGLE_ENABLE),
  .RANGE_XY_DOUBLE(RANGE_XY_DOUBLE), .RANGE_Z_DOUBLE(RANGE_Z_DOUBLE),
  .THRESH_EVENT(THRESH_EVENT));

/* sim/smtc_host.sv */
// Purpose : Host controller model on the register port and trigger lines
// Assumes : Signals change at the falling clock edge only
// Notes   : Released address and data show inverted values, never stale ones
`timescale 1ns/1ps
module smtc_host (
  input  wire logic       CLK_SYS,
  output logic            REG_WR,
  output logic            REG_RD,
  output logic      [7:0] REG_ADDR,
  output logic      [7:0] REG_WDATA,
  input  wire logic [7:0] REG_RDATA,
  output logic            CMD_TRIG,
  output logic            TRIG_PIN_N
);
  initial begin
    REG_WR     = 1'b0;
    REG_RD     = 1'b0;
    REG_ADDR   = 8'h00;
    REG_WDATA  = 8'h00;
    CMD_TRIG   = 1'b0;
    TRIG_PIN_N = 1'b1;
  end

  // Callers may pass an undefined address or reserved bits; nothing is checked here
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK_SYS);
    REG_ADDR  = a;
    REG_WDATA = d;
    REG_WR    = 1'b1;
    @(negedge CLK_SYS);
    REG_WR    = 1'b0;
    REG_ADDR  = ~a;
    REG_WDATA = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge CLK_SYS);
    REG_ADDR = a;
    REG_RD   = 1'b1;
    @(negedge CLK_SYS);
    REG_RD   = 1'b0;
    REG_ADDR = ~a;
    d        = REG_RDATA;
  endtask

  task automatic cmd();
    @(negedge CLK_SYS);
    CMD_TRIG = 1'b1;
    @(negedge CLK_SYS);
    CMD_TRIG = 1'b0;
  endtask

  task automatic pin(input logic lvl);
    @(negedge CLK_SYS);
    TRIG_PIN_N = lvl;
  endtask
endmodule // smtc_host

/* sim/smtc_config_tb.sv */
// Purpose : Self-checking bench of the configuration bank
// Assumes : Millisecond tick shortened to 4 cycles
// Notes   : Bench stands in for the conversion engine
`timescale 1ns/1ps
module smtc_config_tb
  import smtc_pkg::*;
;
  logic       clk_sys, arst_n, reg_wr, reg_rd, cmd_trig, trig_pin_n, duty_exit;
  logic       conv_done, result_valid, conv_start, conv_busy, low_noise, glitch_bypass;
  logic       axis_sequence, angle_enable, range_xy, range_z, thresh_event;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, field_x, limit_x, field_y, limit_y;
  logic [1:0] power_state, angle_first, angle_second, gain_axis;
  logic [2:0] axis_enable;
  logic [7:0] axes_exp [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                                 8'h0b, 8'h0b, 8'h0e, 8'h0d};
  logic [7:0] ang_exp [8] = '{8'h00, 8'h00, 8'h59, 8'h5a, 8'h6e, 8'h6f, 8'h5d, 8'h5f};
  int         mismatches;
  int         total_checks;

  smtc_config #(.MS_TICKS(4)) u_dut (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .CMD_TRIG(cmd_trig), .TRIG_PIN_N(trig_pin_n), .DUTY_EXIT(duty_exit),
    .CONV_DONE(conv_done), .RESULT_VALID(result_valid), .FIELD_X(field_x),
    .FIELD_Y(field_y), .FIELD_Z(field_y), .LIMIT_X(limit_x), .LIMIT_Y(limit_y),
    .LIMIT_Z(limit_y), .CONV_START(conv_start), .CONV_BUSY(conv_busy),
    .POWER_STATE(power_state), .LOW_NOISE(low_noise), .GLITCH_BYPASS(glitch_bypass),
    .AXIS_ENABLE(axis_enable), .AXIS_SEQUENCE(axis_sequence),
    .ANGLE_ENABLE(angle_enable), .ANGLE_FIRST(angle_first),
    .ANGLE_SECOND(angle_second), .GAIN_AXIS(gain_axis), .RANGE_XY_DOUBLE(range_xy),
    .RANGE_Z_DOUBLE(range_z), .THRESH_EVENT(thresh_event));

  smtc_host u_host (
    .CLK_SYS(clk_sys), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .CMD_TRIG(cmd_trig),
    .TRIG_PIN_N(trig_pin_n));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk("rdata", e, d);
  endtask

  // Every start inside the window is counted, so extra starts show up
  task automatic starts(input int n, input logic [7:0] e);
    logic [7:0] c;
    c = 8'h00;
    repeat (n) begin
      if (conv_start === 1'b1) c++;
      @(negedge clk_sys);
    end
    chk("starts", e, c);
  endtask

  task automatic pulse_done();
    @(negedge clk_sys);
    conv_done = 1'b1;
    @(negedge clk_sys);
    conv_done = 1'b0;
  endtask

  task automatic ev(input logic [7:0] f, input logic e);
    @(negedge clk_sys);
    field_x      = f;
    field_y      = f;
    result_valid = 1'b1;
    @(negedge clk_sys);
    result_valid = 1'b0;
    field_x      = ~f;
    field_y      = ~f;
    chk("event", {7'h0, e}, {7'h0, thresh_event});
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end

  initial begin
    {arst_n, duty_exit, conv_done, result_valid} = 4'h0;
    field_x = 8'h00;
    field_y = 8'h00;
    limit_y = 8'h00;
    limit_x = 8'h00;
    repeat (5) @(negedge clk_sys);
    arst_n = 1'b1;
    rdchk(OFS_POWER_TRIGGER, RST_POWER_TRIGGER);
    rdchk(OFS_CHANNEL_INTERVAL, RST_CHANNEL_INTERVAL);
    rdchk(OFS_THRESHOLD_ANGLE, RST_THRESHOLD_ANGLE);
    u_host.wr(8'h04, 8'h5a);
    rdchk(8'h04, 8'h00);
    u_host.wr(OFS_POWER_TRIGGER, 8'h19);
    chk("ctl", 8'h0d, {4'h0, low_noise, glitch_bypass, power_state});
    rdchk(OFS_POWER_TRIGGER, 8'h19);
    u_host.cmd();
    starts(5, 8'h00);
    u_host.wr(OFS_THRESHOLD_ANGLE, 8'hff);
    rdchk(OFS_THRESHOLD_ANGLE, MASK_THRESHOLD_ANGLE);
    chk("range", 8'h03, {6'h0, range_xy, range_z});
    for (int i = 0; i < 12; i++) begin
      u_host.wr(OFS_CHANNEL_INTERVAL, {i[3:0], 4'h0});
      @(negedge clk_sys);
      chk("axes", axes_exp[i], {4'h0, axis_sequence, axis_enable});
    end
    for (int i = 0; i < 8; i++) begin
      u_host.wr(OFS_THRESHOLD_ANGLE, {3'h0, i[0], i[2:1], 2'h0});
      @(negedge clk_sys);
      chk("angle", ang_exp[i], {1'b0, angle_enable, angle_first, angle_second,
          gain_axis});
    end
    $display("test registers finished");
    u_host.wr(OFS_POWER_TRIGGER, 8'h00);
    u_host.cmd();
    starts(3, 8'h01);
    u_host.cmd();
    u_host.cmd();
    starts(3, 8'h00);
    pulse_done();
    starts(3, 8'h01);
    pulse_done();
    starts(4, 8'h00);
    chk("busy", 8'h00, {7'h0, conv_busy});
    u_host.cmd();
    fork
      u_host.cmd();
      pulse_done();
    join
    starts(3, 8'h01);
    pulse_done();
    u_host.wr(OFS_POWER_TRIGGER, 8'h04);
    u_host.cmd();
    starts(5, 8'h00);
    u_host.pin(1'b0);
    starts(8, 8'h01);
    u_host.pin(1'b1);
    pulse_done();
    $display("test trigger finished");
    u_host.wr(OFS_CHANNEL_INTERVAL, 8'h10);
    u_host.wr(OFS_POWER_TRIGGER, 8'h02);
    starts(5, 8'h01);
    u_host.wr(OFS_POWER_TRIGGER, 8'h03);
    pulse_done();
    starts(20, 8'h01);
    @(negedge clk_sys);
    duty_exit = 1'b1;
    @(negedge clk_sys);
    duty_exit = 1'b0;
    chk("mode", 8'h00, {6'h0, power_state});
    pulse_done();
    rdchk(OFS_POWER_TRIGGER, 8'h00);
    $display("test modes finished");
    u_host.wr(OFS_THRESHOLD_ANGLE, 8'h00);
    limit_x = 8'h05;
    ev(8'h10, 1'b1);
    ev(8'h03, 1'b0);
    u_host.wr(OFS_THRESHOLD_ANGLE, 8'h20);
    ev(8'h03, 1'b1);
    ev(8'h10, 1'b0);
    u_host.wr(OFS_THRESHOLD_ANGLE, 8'h40);
    repeat (3) ev(8'h10, 1'b0);
    ev(8'h10, 1'b1);
    u_host.wr(OFS_THRESHOLD_ANGLE, 8'h00);
    u_host.wr(OFS_POWER_TRIGGER, 8'h20);
    limit_x = 8'h85;
    ev(8'hf6, 1'b1);
    ev(8'h03, 1'b0);
    limit_x = 8'h00;
    ev(8'h10, 1'b0);
    limit_y = 8'h05;
    ev(8'h10, 1'b0);
    u_host.wr(OFS_CHANNEL_INTERVAL, 8'h20);
    ev(8'h10, 1'b1);
    u_host.wr(OFS_CHANNEL_INTERVAL, 8'h40);
    ev(8'h10, 1'b1);
    $display("test threshold finished");
    test_done();
  end
endmodule // smtc_config_tb
